// ===== rtl/pllcfg_map.svh
`ifndef PLLCFG_MAP_SVH
`define PLLCFG_MAP_SVH
// Byte addresses of the configuration image words, the status word and the decode word
`define PLLCFG_ADDR_CFG_LO 12'h000
`define PLLCFG_ADDR_CFG_HI 12'h004
`define PLLCFG_ADDR_STATUS 12'h008
`define PLLCFG_ADDR_DECODE 12'h00c
// Field positions within the 64-bit image
`define PLLCFG_REF_LSB 0
`define PLLCFG_REF_MSB 11
`define PLLCFG_P1_LSB 16
`define PLLCFG_P2_LSB 18
`define PLLCFG_P3_LSB 20
`define PLLCFG_RSV_LSB 22
`define PLLCFG_FBK_LSB 24
`define PLLCFG_FBK_MSB 37
`define PLLCFG_FBK_A_MSB 26
`define PLLCFG_FBK_M_LSB 27
`define PLLCFG_MAIN_PUMP_CURRENT_LSB 40
`define PLLCFG_FILTER_TIME_CONSTANT_BIT 43
`define PLLCFG_VCO_RANGE_SELECT_BIT 44
`define PLLCFG_XROM_LSB 49
`define PLLCFG_XROM_MSB 51
`define PLLCFG_CRYSTAL_PUMP_CURRENT_LSB 52
`define PLLCFG_SWAP_BIT 54
`define PLLCFG_XPD_BIT 55
`define PLLCFG_XCT_LSB 56
`define PLLCFG_XCT_MSB 59
`define PLLCFG_CMOS_BIT 60
`define PLLCFG_FINE_BIT 61
`define PLLCFG_STAT_LSB 62
`define PLLCFG_STAT_MSB 63
// Reset image and divider constants
`define PLLCFG_CFG_RESET 64'h0000_0000_0000_0000
`define PLLCFG_XDIV_PD 13'h0000
`define PLLCFG_XDIV_1 13'h0001
`define PLLCFG_XDIV_3072 13'h0c00
`define PLLCFG_XDIV_3156 13'h0c54
`define PLLCFG_XDIV_2430 13'h097e
`define PLLCFG_XDIV_2500 13'h09c4
`define PLLCFG_XDIV_4000 13'h0fa0
`define PLLCFG_XDIV_3375 13'h0d2f
`define PLLCFG_XROM_PD 3'h7
// Pump currents in tenths of a microamp
`define PLLCFG_I_1P5 8'h0f
`define PLLCFG_I_5 8'h32
`define PLLCFG_I_8 8'h50
`define PLLCFG_I_24 8'hf0
`endif

// ===== rtl/pllcfg_pkg.sv
package pllcfg_pkg;
    // What the lock indicator pin reports
    typedef enum logic [1:0] {
        PLLCFG_SRC_XLOCK,
        PLLCFG_SRC_XRANGE,
        PLLCFG_SRC_PHASE,
        PLLCFG_SRC_FBK
    } pllcfg_stat_t;
endpackage

// ===== rtl/pllcfg_decode.sv
// Notes on behaviour
// - Status mode bits 63:62 select lock pin source among four loop signals.
// - In CMOS mode pin is high for locked/high range; mode bit reads pin.
// - VCO speed bit 44: 0 high range, 1 low range.
// - Main pump code 41:40 gives 1.5, 5, 8 or 24 uA.
// - Filter bit 43: 0 short 13.5 us, 1 long 135 us.
// - Reference modulus is image bits 11:0 unsigned.
// - Feedback field 37:24; low three bits A counter, upper eleven M.
// - First post divider codes give 1, 2, 4, 8.
// - Second post divider codes give 1, 3, 5, 4.
// - Third post divider codes give 1, 3, 5, 4.
// - Crystal pump code 53:52 gives 1.5, 5, 8 or 24 uA.
// - Bits 51:49 pick crystal divider from table; one code powers oscillator down.
// - Fine tune enable bit 61: 0 inactive, 1 active.
// - Polarity bit 54: 0 rising VCXO, 1 inverted sense for internal oscillator.
// - Bit 55: 0 crystal loop runs, 1 crystal loop powered down.
// - Coarse code 59:56 selects crystal load capacitance step.
// - Table: 000 div 1, then 3072,3156,2430,2500,4000,3375; 111 power-down.
// - Output bit 60: 0 PECL drive, 1 CMOS with lock indicator.
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pllcfg_map.svh"
module pllcfg_decode (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Loop status inputs from analog blocks, asynchronous
    input wire logic crystal_locked,
    input wire logic crystal_range_high,
    input wire logic main_phase_aligned,
    input wire logic feedback_divider_out,
    // Lock status pin
    output logic lock_indicator_pin,
    output logic lock_indicator_pin_oe,
    // Main loop controls
    output logic vco_range_select,
    output logic [7:0] main_pump_current,
    output logic filter_time_constant,
    // Dividers
    output logic [11:0] reference_modulus,
    output logic [13:0] feedback_modulus,
    output logic [2:0] feedback_a_count,
    output logic [10:0] feedback_m_count,
    output logic [3:0] output_divider_first,
    output logic [2:0] output_divider_second,
    output logic [2:0] output_divider_third,
    // Crystal loop controls
    output logic [7:0] crystal_pump_current,
    output logic [2:0] crystal_divider_select,
    output logic [12:0] crystal_divider_value,
    output logic oscillator_powerdown,
    output logic fine_tune_enable,
    output logic tune_polarity_invert,
    output logic crystal_loop_powerdown,
    output logic [3:0] coarse_load_tune,
    output logic cmos_output_select
);
    logic [63:0] cfg;
    logic [63:0] next_cfg;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic lock_pin_level;
    logic wr_fire;
    logic [31:0] next_prdata;
    pllcfg_pkg::pllcfg_stat_t stat_src;
    logic next_lock_indicator_pin;
    logic next_lock_indicator_pin_oe;
    logic next_vco_range_select;
    logic [7:0] next_main_pump_current;
    logic next_filter_time_constant;
    logic [11:0] next_reference_modulus;
    logic [13:0] next_feedback_modulus;
    logic [2:0] next_feedback_a_count;
    logic [10:0] next_feedback_m_count;
    logic [3:0] next_output_divider_first;
    logic [2:0] next_output_divider_second;
    logic [2:0] next_output_divider_third;
    logic [7:0] next_crystal_pump_current;
    logic [2:0] next_crystal_divider_select;
    logic [12:0] next_crystal_divider_value;
    logic next_oscillator_powerdown;
    logic next_fine_tune_enable;
    logic next_tune_polarity_invert;
    logic next_crystal_loop_powerdown;
    logic [3:0] next_coarse_load_tune;
    logic next_cmos_output_select;

    // Pump code to current in tenths of a microamp
    function automatic logic [7:0] pump_ua(input logic [1:0] code);
        unique case (code)
            2'h0: pump_ua = `PLLCFG_I_1P5;
            2'h1: pump_ua = `PLLCFG_I_5;
            2'h2: pump_ua = `PLLCFG_I_8;
            2'h3: pump_ua = `PLLCFG_I_24;
        endcase
    endfunction

    // Second and third post dividers share one code map
    function automatic logic [2:0] post_odd(input logic [1:0] code);
        unique case (code)
            2'h0: post_odd = 3'h1;
            2'h1: post_odd = 3'h3;
            2'h2: post_odd = 3'h5;
            2'h3: post_odd = 3'h4;
        endcase
    endfunction

    // Zero wait-state APB: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_fire = psel & penable & pwrite;

    // Byte-lane writes into the image; untouched bytes hold their value
    always_comb begin
        next_cfg = cfg;
        for (int b = 0; b < 4; b++) begin
            if (wr_fire && pstrb[b] && paddr == `PLLCFG_ADDR_CFG_LO) begin
                next_cfg[8*b +: 8] = pwdata[8*b +: 8];
            end
            if (wr_fire && pstrb[b] && paddr == `PLLCFG_ADDR_CFG_HI) begin
                next_cfg[32 + 8*b +: 8] = pwdata[8*b +: 8];
            end
        end
        next_cfg[`PLLCFG_RSV_LSB +: 2] = 2'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= `PLLCFG_CFG_RESET;
        end else begin
            cfg <= next_cfg;
        end
    end

    // Two-flop synchronisers for the asynchronous loop status inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end else begin
            sync1 <= {feedback_divider_out, main_phase_aligned, crystal_range_high, crystal_locked};
            sync2 <= sync1;
        end
    end

    always_comb begin
        stat_src = pllcfg_pkg::pllcfg_stat_t'(cfg[`PLLCFG_STAT_MSB:`PLLCFG_STAT_LSB]);
        unique case (stat_src)
            pllcfg_pkg::PLLCFG_SRC_XLOCK: lock_pin_level = sync2[0];
            pllcfg_pkg::PLLCFG_SRC_XRANGE: lock_pin_level = sync2[1];
            pllcfg_pkg::PLLCFG_SRC_PHASE: lock_pin_level = sync2[2];
            pllcfg_pkg::PLLCFG_SRC_FBK: lock_pin_level = sync2[3];
        endcase
    end

    // Read mux; high image word shows the pin level in mode bit 63 when CMOS bit 60 is set
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (paddr)
            `PLLCFG_ADDR_CFG_LO: next_prdata = cfg[31:0];
            `PLLCFG_ADDR_CFG_HI: begin
                next_prdata = cfg[63:32];
                if (cfg[`PLLCFG_CMOS_BIT]) begin
                    next_prdata[`PLLCFG_STAT_MSB - 32] = lock_pin_level;
                end
            end
            `PLLCFG_ADDR_STATUS: next_prdata = {28'h000_0000, sync2};
            `PLLCFG_ADDR_DECODE: next_prdata = {3'h0, oscillator_powerdown, crystal_divider_value,
                                                lock_pin_level, output_divider_third, output_divider_second,
                                                output_divider_first, lock_indicator_pin, 3'h0};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // Read data held in a flop, refreshed during setup so it is valid in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // CMOS drives indicator, PECL leaves pin to programming current
    always_comb begin
        next_lock_indicator_pin = cfg[`PLLCFG_CMOS_BIT] & lock_pin_level;
        next_lock_indicator_pin_oe = cfg[`PLLCFG_CMOS_BIT];
    end

    // Pin flop keeps the pin glitch-free while the source mux switches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_indicator_pin <= 1'b0;
            lock_indicator_pin_oe <= 1'b0;
        end else begin
            lock_indicator_pin <= next_lock_indicator_pin;
            lock_indicator_pin_oe <= next_lock_indicator_pin_oe;
        end
    end

    // Decode of the held image; a partial write shows one edge later
    always_comb begin
        next_vco_range_select = cfg[`PLLCFG_VCO_RANGE_SELECT_BIT];
        next_main_pump_current = pump_ua(cfg[`PLLCFG_MAIN_PUMP_CURRENT_LSB +: 2]);
        next_filter_time_constant = cfg[`PLLCFG_FILTER_TIME_CONSTANT_BIT];
        next_reference_modulus = cfg[`PLLCFG_REF_MSB:`PLLCFG_REF_LSB];
        next_feedback_modulus = cfg[`PLLCFG_FBK_MSB:`PLLCFG_FBK_LSB];
        next_feedback_a_count = cfg[`PLLCFG_FBK_A_MSB:`PLLCFG_FBK_LSB];
        next_feedback_m_count = cfg[`PLLCFG_FBK_MSB:`PLLCFG_FBK_M_LSB];
        next_output_divider_first = 4'h1 << cfg[`PLLCFG_P1_LSB +: 2];
        next_output_divider_second = post_odd(cfg[`PLLCFG_P2_LSB +: 2]);
        next_output_divider_third = post_odd(cfg[`PLLCFG_P3_LSB +: 2]);
        next_crystal_pump_current = pump_ua(cfg[`PLLCFG_CRYSTAL_PUMP_CURRENT_LSB +: 2]);
        next_crystal_divider_select = cfg[`PLLCFG_XROM_MSB:`PLLCFG_XROM_LSB];
        next_oscillator_powerdown = cfg[`PLLCFG_XROM_MSB:`PLLCFG_XROM_LSB] == `PLLCFG_XROM_PD;
        unique case (cfg[`PLLCFG_XROM_MSB:`PLLCFG_XROM_LSB])
            3'h0: next_crystal_divider_value = `PLLCFG_XDIV_1;
            3'h1: next_crystal_divider_value = `PLLCFG_XDIV_3072;
            3'h2: next_crystal_divider_value = `PLLCFG_XDIV_3156;
            3'h3: next_crystal_divider_value = `PLLCFG_XDIV_2430;
            3'h4: next_crystal_divider_value = `PLLCFG_XDIV_2500;
            3'h5: next_crystal_divider_value = `PLLCFG_XDIV_4000;
            3'h6: next_crystal_divider_value = `PLLCFG_XDIV_3375;
            3'h7: next_crystal_divider_value = `PLLCFG_XDIV_PD;
        endcase
        next_fine_tune_enable = cfg[`PLLCFG_FINE_BIT];
        next_tune_polarity_invert = cfg[`PLLCFG_SWAP_BIT];
        next_crystal_loop_powerdown = cfg[`PLLCFG_XPD_BIT];
        next_coarse_load_tune = cfg[`PLLCFG_XCT_MSB:`PLLCFG_XCT_LSB];
        next_cmos_output_select = cfg[`PLLCFG_CMOS_BIT];
    end

    // Decoded controls, registered from the held image
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_range_select <= 1'b0;
            main_pump_current <= `PLLCFG_I_1P5;
            filter_time_constant <= 1'b0;
            reference_modulus <= 12'h000;
            feedback_modulus <= 14'h0000;
            feedback_a_count <= 3'h0;
            feedback_m_count <= 11'h000;
            output_divider_first <= 4'h1;
            output_divider_second <= 3'h1;
            output_divider_third <= 3'h1;
            crystal_pump_current <= `PLLCFG_I_1P5;
            crystal_divider_select <= 3'h0;
            crystal_divider_value <= `PLLCFG_XDIV_1;
            oscillator_powerdown <= 1'b0;
            fine_tune_enable <= 1'b0;
            tune_polarity_invert <= 1'b0;
            crystal_loop_powerdown <= 1'b0;
            coarse_load_tune <= 4'h0;
            cmos_output_select <= 1'b0;
        end else begin
            vco_range_select <= next_vco_range_select;
            main_pump_current <= next_main_pump_current;
            filter_time_constant <= next_filter_time_constant;
            reference_modulus <= next_reference_modulus;
            feedback_modulus <= next_feedback_modulus;
            feedback_a_count <= next_feedback_a_count;
            feedback_m_count <= next_feedback_m_count;
            output_divider_first <= next_output_divider_first;
            output_divider_second <= next_output_divider_second;
            output_divider_third <= next_output_divider_third;
            crystal_pump_current <= next_crystal_pump_current;
            crystal_divider_select <= next_crystal_divider_select;
            crystal_divider_value <= next_crystal_divider_value;
            oscillator_powerdown <= next_oscillator_powerdown;
            fine_tune_enable <= next_fine_tune_enable;
            tune_polarity_invert <= next_tune_polarity_invert;
            crystal_loop_powerdown <= next_crystal_loop_powerdown;
            coarse_load_tune <= next_coarse_load_tune;
            cmos_output_select <= next_cmos_output_select;
        end
    end
endmodule
`default_nettype wire

// ===== tb/pllcfg_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pllcfg_chk (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Status input and pin
    input wire logic crystal_locked,
    input wire logic lock_indicator_pin,
    input wire logic lock_indicator_pin_oe,
    // Decoded fields
    input wire logic vco_range_select,
    input wire logic [7:0] main_pump_current,
    input wire logic [11:0] reference_modulus,
    input wire logic [2:0] feedback_a_count,
    input wire logic [10:0] feedback_m_count,
    input wire logic [3:0] output_divider_first
);
    logic [63:0] img, img_q;
    logic [7:0] pump_tab [4] = '{8'h0f, 8'h32, 8'h50, 8'hf0};
    wire wr = psel && penable && pwrite && pready;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow image; img_q lines up with the output flops, one edge after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            img <= 64'h0000_0000_0000_0000;
            img_q <= 64'h0000_0000_0000_0000;
        end else begin
            img_q <= img;
            if (wr && paddr == 12'h000) img[31:0] <= pwdata;
            if (wr && paddr == 12'h004) img[63:32] <= pwdata;
        end
    end
    property p_ref; reference_modulus == img_q[11:0]; endproperty
    a_ref: assert property (p_ref) else $error("reference modulus off");
    property p_fbk; {feedback_m_count, feedback_a_count} == img_q[37:24]; endproperty
    a_fbk: assert property (p_fbk) else $error("feedback counters off");
    property p_vco; vco_range_select == img_q[44]; endproperty
    a_vco: assert property (p_vco) else $error("vco range off");
    property p_pump; main_pump_current == pump_tab[img_q[41:40]]; endproperty
    a_pump: assert property (p_pump) else $error("main pump current off");
    property p_post; output_divider_first == (4'h1 << img_q[17:16]); endproperty
    a_post: assert property (p_post) else $error("first post divider off");
    property p_pecl; lock_indicator_pin_oe == img_q[60] && (img_q[60] || !lock_indicator_pin); endproperty
    a_pecl: assert property (p_pecl) else $error("lock pin driven in pecl mode");
    property p_hold; !wr [*2] |=> $stable(reference_modulus) && $stable(main_pump_current); endproperty
    a_hold: assert property (p_hold) else $error("field moved without write");
    property p_lock; (img_q[60] && img_q[63:62] == 2'h0 && $stable(crystal_locked)) [*4] |-> lock_indicator_pin == crystal_locked; endproperty
    a_lock: assert property (p_lock) else $error("lock pin not following crystal lock");
endmodule
`default_nettype wire

// ===== tb/pllcfg_host.sv
`timescale 1ns/1ps
`default_nettype none
module pllcfg_host (
    // Clock and slave answer
    input wire logic pclk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // Slave never answered
    output logic hang
);
    // Whole words only, so the shadow image never sees partial lanes
    assign pstrb = 4'hf;
    initial {psel, penable, pwrite, hang, paddr, pwdata} = 48'h0000_0000_0000;
    // One transfer; released lines show the inverse so stale values never pass
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= (a == 12'h000) ? (d & 32'hff3f_ffff) : d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n++;
        end
        hang <= (n >= 16);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, hang, crystal_locked, crystal_range_high;
    logic main_phase_aligned, feedback_divider_out, lock_indicator_pin, lock_indicator_pin_oe, vco_range_select;
    logic filter_time_constant, oscillator_powerdown, fine_tune_enable, tune_polarity_invert;
    logic crystal_loop_powerdown, cmos_output_select;
    logic [2:0] feedback_a_count, output_divider_second, output_divider_third, crystal_divider_select;
    logic [3:0] pstrb, output_divider_first, coarse_load_tune;
    logic [3:0] loops = 4'h0;
    logic [7:0] main_pump_current, crystal_pump_current;
    logic [10:0] feedback_m_count;
    logic [11:0] paddr, reference_modulus;
    logic [12:0] crystal_divider_value;
    logic [13:0] feedback_modulus;
    logic [31:0] pwdata, prdata, q;
    int errors = 0;
    int n_compared = 0;
    // Loop status levels come from the bench in place of the analog blocks
    assign {feedback_divider_out, main_phase_aligned, crystal_range_high, crystal_locked} = loops;
    pllcfg_decode dut (
        .pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_locked(crystal_locked), .crystal_range_high(crystal_range_high),
        .main_phase_aligned(main_phase_aligned), .feedback_divider_out(feedback_divider_out),
        .lock_indicator_pin(lock_indicator_pin), .lock_indicator_pin_oe(lock_indicator_pin_oe),
        .vco_range_select(vco_range_select), .main_pump_current(main_pump_current),
        .filter_time_constant(filter_time_constant), .reference_modulus(reference_modulus),
        .feedback_modulus(feedback_modulus), .feedback_a_count(feedback_a_count),
        .feedback_m_count(feedback_m_count), .output_divider_first(output_divider_first),
        .output_divider_second(output_divider_second), .output_divider_third(output_divider_third),
        .crystal_pump_current(crystal_pump_current), .crystal_divider_select(crystal_divider_select),
        .crystal_divider_value(crystal_divider_value), .oscillator_powerdown(oscillator_powerdown),
        .fine_tune_enable(fine_tune_enable), .tune_polarity_invert(tune_polarity_invert),
        .crystal_loop_powerdown(crystal_loop_powerdown), .coarse_load_tune(coarse_load_tune),
        .cmos_output_select(cmos_output_select)
    );
    pllcfg_host host (
        .pclk(pclk), .pready(pready), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .hang(hang)
    );
    // 125 MHz clock
    always #4 pclk = ~pclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Write, then look after the output flops have taken it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic rd(input logic [11:0] a);
        host.xfer(1'b0, a, 32'h0000_0000, q);
    endtask
    task automatic t_codes();
        logic [7:0] pump [4] = '{8'h0f, 8'h32, 8'h50, 8'hf0};
        logic [2:0] post [4] = '{3'h1, 3'h3, 3'h5, 3'h4};
        logic [12:0] xdiv [8] = '{13'h0001, 13'h0c00, 13'h0c54, 13'h097e, 13'h09c4, 13'h0fa0, 13'h0d2f, 13'h0000};
        for (int c = 0; c < 8; c++) begin
            wr(12'h004, (c << 17) | ((c % 4) << 20) | ((c % 4) << 8));
            wr(12'h000, ((c % 4) << 20) | ((c % 4) << 18) | ((c % 4) << 16));
            chk(main_pump_current, pump[c % 4]);
            chk(crystal_pump_current, pump[c % 4]);
            chk(output_divider_first, 1 << (c % 4));
            chk(output_divider_second, post[c % 4]);
            chk(output_divider_third, post[c % 4]);
            chk(crystal_divider_value, xdiv[c]);
            chk(oscillator_powerdown, c == 7);
            chk(crystal_divider_select, c);
        end
    endtask
    task automatic t_fields();
        logic [31:0] hi [2] = '{32'h2a80_083f, 32'h0540_1000};
        logic [31:0] lo [2] = '{32'hab00_0fff, 32'h0000_0001};
        for (int i = 0; i < 2; i++) begin
            wr(12'h000, lo[i]);
            wr(12'h004, hi[i]);
            chk(reference_modulus, lo[i][11:0]);
            chk(feedback_modulus, {hi[i][5:0], lo[i][31:24]});
            chk(vco_range_select, hi[i][12]);
            chk(filter_time_constant, hi[i][11]);
            chk(fine_tune_enable, hi[i][29]);
            chk(tune_polarity_invert, hi[i][22]);
            chk(crystal_loop_powerdown, hi[i][23]);
            chk(coarse_load_tune, hi[i][27:24]);
        end
        // Unmapped place reads zero and its write touches nothing
        wr(12'h010, 32'hffff_ffff);
        rd(12'h010);
        chk(q, 32'h0000_0000);
        chk(reference_modulus, 12'h001);
        chk({pready, pslverr}, 2'h2);
    endtask
    task automatic t_lock();
        for (int s = 0; s < 4; s++) begin
            wr(12'h004, 32'h1000_0000 | (s << 30));
            for (int v = 0; v < 2; v++) begin
                @(posedge pclk);
                loops <= v ? ~(4'h1 << s) : (4'h1 << s);
                repeat (4) @(posedge pclk);
                rd(12'h004);
                chk(lock_indicator_pin, v == 0);
                chk(lock_indicator_pin_oe, 1'b1);
                chk(cmos_output_select, 1'b1);
                chk(q[31], v == 0);
                rd(12'h008);
                chk(q, {28'h000_0000, loops});
            end
        end
        wr(12'h004, 32'h0000_0000);
        @(negedge pclk);
        chk({cmos_output_select, lock_indicator_pin_oe, lock_indicator_pin}, 3'h0);
    endtask
    // Hang guards
    always @(posedge hang) begin
        errors++;
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_codes();
        t_fields();
        t_lock();
        finish_test();
    end
endmodule
bind pllcfg_decode pllcfg_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .crystal_locked(crystal_locked), .lock_indicator_pin(lock_indicator_pin),
    .lock_indicator_pin_oe(lock_indicator_pin_oe), .vco_range_select(vco_range_select),
    .main_pump_current(main_pump_current), .reference_modulus(reference_modulus),
    .feedback_a_count(feedback_a_count), .feedback_m_count(feedback_m_count),
    .output_divider_first(output_divider_first)
);
`default_nettype wire
